/* File: logic/frd_pkg.sv */
package frd_pkg;

   // ****************************************
   // Bus and memory geometry
   // ****************************************
   localparam int          APB_ADDR_W      = 8;
   localparam int          DATA_W          = 32;
   localparam int          MEM_ADDR_W      = 12;
   localparam int          MEM_DEPTH       = 4096;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_INSTR       = 8'h04;
   localparam logic [7:0]  OFS_BANK_SEL    = 8'h08;
   localparam logic [7:0]  OFS_ACCUM       = 8'h0c;
   localparam logic [7:0]  OFS_STATUS      = 8'h10;
   localparam logic [7:0]  OFS_INDEX_BASE  = 8'h14;
   localparam logic [7:0]  OFS_MEM_ADDR    = 8'h18;
   localparam logic [7:0]  OFS_MEM_DATA    = 8'h1c;

   // ****************************************
   // Instruction word fields
   // ****************************************
   localparam int          OPC_LSB         = 10;
   localparam int          OPC_MSB         = 15;
   localparam logic [5:0]  OPC_DECREMENT   = 6'h01;
   localparam int          DEST_BIT        = 9;
   localparam int          BANK_MODE_BIT   = 8;
   localparam int          FILE_MSB        = 7;

   // ****************************************
   // Access bank and indexed mode
   // ****************************************
   localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;
   localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;

   // ****************************************
   // Control and status fields
   // ****************************************
   localparam int          CTRL_EXT_BIT    = 0;
   localparam int          ST_CARRY        = 0;
   localparam int          ST_NIBBLE       = 1;
   localparam int          ST_ZERO         = 2;
   localparam int          ST_WRAP         = 3;
   localparam int          ST_NEG          = 4;
   localparam int          ST_BUSY         = 8;
   localparam int          ST_BAD_OP       = 9;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] RST_INSTR       = 16'h0000;
   localparam logic [3:0]  RST_BANK_SEL    = 4'h0;
   localparam logic [7:0]  RST_ACCUM       = 8'h00;
   localparam logic [4:0]  RST_FLAGS       = 5'h00;
   localparam logic [11:0] RST_INDEX_BASE  = 12'h000;
   localparam logic [11:0] RST_MEM_ADDR    = 12'h000;

   typedef enum logic [2:0] {
      FRD_IDLE,
      FRD_Q1,
      FRD_Q2,
      FRD_Q3,
      FRD_Q4
   } frd_phase_t;

endpackage : frd_pkg

/* File: logic/frd_dec_alu.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Decrement arithmetic and flags
// ****************************************
module frd_dec_alu
   import frd_pkg::*;
(
   input  wire logic [7:0] operand,
   output logic      [7:0] result,
   output logic            carry_flag,
   output logic            nibble_borrow_flag,
   output logic            zero_flag,
   output logic            signed_wrap_flag,
   output logic            negative_flag
);

   // Wraps from 00 to ff by plain 8-bit arithmetic
   assign result             = operand - 8'h01;
   // Carry means no borrow: only a zero operand borrows
   assign carry_flag         = (operand != 8'h00);
   assign nibble_borrow_flag = (operand[3:0] != 4'h0);
   assign zero_flag          = (result == 8'h00);
   assign signed_wrap_flag   = (operand == 8'h80);
   assign negative_flag      = result[7];

endmodule : frd_dec_alu

`default_nettype wire

/* File: logic/frd_core.sv */
// Operation
// - result is addressed byte minus one, wrapping
// - destination zero writes accumulator, memory untouched
// - destination one writes back same location
// - bank mode zero uses the access bank
// - bank mode one prefixes bank select register
// - extended set, access mode, f<=5f indexes
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module frd_core
   import frd_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0]     pwdata,
   output logic      [DATA_W-1:0]     prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic      [7:0]            accumulator,
   output logic      [4:0]            status_flags,
   output logic                       busy
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0]             data_mem [MEM_DEPTH];
   frd_phase_t             phase;
   logic [15:0]            instr;
   logic [3:0]             bank_select_register;
   logic                   ext_set_enable;
   logic [11:0]            index_base;
   logic [11:0]            mem_addr;
   logic                   bad_op;
   logic [11:0]            eff_addr;
   logic [7:0]             operand;
   logic [7:0]             result_q;
   logic [4:0]             flags_q;
   logic [DATA_W-1:0]      next_prdata;
   logic                   next_slverr;
   logic                   exec_tail;

   // ****************************************
   // Bus decode
   // ****************************************
   wire                    setup_phase  = psel && !penable;
   wire                    access_phase = psel && penable;
   wire                    wr_done      = access_phase && pready && pwrite;
   wire                    hit_ctrl     = (paddr == OFS_CTRL);
   wire                    hit_instr    = (paddr == OFS_INSTR);
   wire                    hit_bank     = (paddr == OFS_BANK_SEL);
   wire                    hit_accum    = (paddr == OFS_ACCUM);
   wire                    hit_status   = (paddr == OFS_STATUS);
   wire                    hit_index    = (paddr == OFS_INDEX_BASE);
   wire                    hit_maddr    = (paddr == OFS_MEM_ADDR);
   wire                    hit_mdata    = (paddr == OFS_MEM_DATA);
   wire                    hit_any      = hit_ctrl || hit_instr || hit_bank || hit_accum
                                          || hit_status || hit_index || hit_maddr
                                          || hit_mdata;

   // Holding the bus while busy keeps software from racing the Q4 write;
   // the tail cycle lets the read flop catch what Q4 has just written
   assign busy   = (phase != FRD_IDLE);
   assign pready = !busy && !exec_tail;

   // ****************************************
   // Instruction decode
   // ****************************************
   wire [5:0]              opcode       = instr[OPC_MSB:OPC_LSB];
   wire                    is_decrement = (opcode == OPC_DECREMENT);
   wire                    dest_file    = instr[DEST_BIT];
   wire                    bank_mode    = instr[BANK_MODE_BIT];
   wire [7:0]              file_addr    = instr[FILE_MSB:0];
   wire                    use_indexed  = ext_set_enable && !bank_mode
                                          && (file_addr <= INDEXED_LIMIT);
   wire [3:0]              access_bank  = (file_addr <= INDEXED_LIMIT) ? ACCESS_LOW_BANK
                                                                       : ACCESS_HI_BANK;
   wire [11:0]             indexed_addr = index_base + {4'h0, file_addr};
   wire [11:0]             next_eff_addr;

   // Indexed form is a plain base-plus-offset; the core has no other
   // indexed pointer behaviour than this sum
   assign next_eff_addr = use_indexed ? indexed_addr
                        : bank_mode   ? {bank_select_register, file_addr}
                                      : {access_bank, file_addr};

   // ****************************************
   // Arithmetic
   // ****************************************
   logic [7:0]             alu_result;
   logic                   alu_carry;
   logic                   alu_nibble;
   logic                   alu_zero;
   logic                   alu_wrap;
   logic                   alu_neg;

   frd_dec_alu u_alu (
      .operand            (operand),
      .result             (alu_result),
      .carry_flag         (alu_carry),
      .nibble_borrow_flag (alu_nibble),
      .zero_flag          (alu_zero),
      .signed_wrap_flag   (alu_wrap),
      .negative_flag      (alu_neg)
   );

   wire [4:0]              alu_flags;

   assign alu_flags[ST_CARRY]  = alu_carry;
   assign alu_flags[ST_NIBBLE] = alu_nibble;
   assign alu_flags[ST_ZERO]   = alu_zero;
   assign alu_flags[ST_WRAP]   = alu_wrap;
   assign alu_flags[ST_NEG]    = alu_neg;

   // ****************************************
   // Four-phase sequencer
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= FRD_IDLE;
      end else begin
         case (phase)
            FRD_IDLE: begin
               if (wr_done && hit_instr) begin
                  phase <= FRD_Q1;
               end
            end
            FRD_Q1: begin
               phase <= is_decrement ? FRD_Q2 : FRD_IDLE;
            end
            FRD_Q2: begin
               phase <= FRD_Q3;
            end
            FRD_Q3: begin
               phase <= FRD_Q4;
            end
            default: begin
               phase <= FRD_IDLE;
            end
         endcase
      end
   end

   // Decode, read and process stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_addr <= RST_MEM_ADDR;
         operand  <= RST_ACCUM;
         result_q <= RST_ACCUM;
         flags_q  <= RST_FLAGS;
      end else begin
         if (phase == FRD_Q1) begin
            eff_addr <= next_eff_addr;
         end
         if (phase == FRD_Q2) begin
            operand <= data_mem[eff_addr];
         end
         if (phase == FRD_Q3) begin
            result_q <= alu_result;
            flags_q  <= alu_flags;
         end
      end
   end

   // ****************************************
   // Software registers
   // ****************************************
   wire                    wr_instr     = wr_done && hit_instr;
   wire                    wr_bank      = wr_done && hit_bank;
   wire                    wr_ctrl      = wr_done && hit_ctrl;
   wire                    wr_index     = wr_done && hit_index;
   wire                    wr_maddr     = wr_done && hit_maddr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr <= RST_INSTR;
      end else if (wr_instr) begin
         instr <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_select_register <= RST_BANK_SEL;
      end else if (wr_bank) begin
         bank_select_register <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_set_enable <= 1'b0;
      end else if (wr_ctrl) begin
         ext_set_enable <= pwdata[CTRL_EXT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_base <= RST_INDEX_BASE;
      end else if (wr_index) begin
         index_base <= pwdata[11:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= RST_MEM_ADDR;
      end else if (wr_maddr) begin
         mem_addr <= pwdata[11:0];
      end
   end

   // Bus writes cannot land while busy, so Q4 and software never collide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulator  <= RST_ACCUM;
         status_flags <= RST_FLAGS;
         bad_op       <= 1'b0;
      end else if (phase == FRD_Q4) begin
         status_flags <= flags_q;
         if (!dest_file) begin
            accumulator <= result_q;
         end
      end else if (phase == FRD_Q1 && !is_decrement) begin
         bad_op <= 1'b1;
      end else if (wr_done && hit_accum) begin
         accumulator <= pwdata[7:0];
      end else if (wr_done && hit_status) begin
         status_flags <= pwdata[4:0];
         bad_op       <= bad_op & ~pwdata[ST_BAD_OP];
      end
   end

   // Memory has no reset; software loads it through the window
   wire                    mem_wr_exec = (phase == FRD_Q4) && dest_file;
   wire                    mem_wr_bus  = wr_done && hit_mdata;

   always_ff @(posedge pclk) begin
      if (mem_wr_exec) begin
         data_mem[eff_addr] <= result_q;
      end else if (mem_wr_bus) begin
         data_mem[mem_addr] <= pwdata[7:0];
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      next_prdata = '0;
      next_slverr = 1'b0;
      if (hit_ctrl) begin
         next_prdata[CTRL_EXT_BIT] = ext_set_enable;
      end else if (hit_instr) begin
         next_prdata[15:0] = instr;
      end else if (hit_bank) begin
         next_prdata[3:0] = bank_select_register;
      end else if (hit_accum) begin
         next_prdata[7:0] = accumulator;
      end else if (hit_status) begin
         next_prdata[4:0]       = status_flags;
         next_prdata[ST_BUSY]   = busy;
         next_prdata[ST_BAD_OP] = bad_op;
      end else if (hit_index) begin
         next_prdata[11:0] = index_base;
      end else if (hit_maddr) begin
         next_prdata[11:0] = mem_addr;
      end else if (hit_mdata) begin
         next_prdata[7:0] = data_mem[mem_addr];
      end else begin
         next_slverr = 1'b1;
      end
   end

   // Q4 lands at the last busy edge, so the bus waits one more cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_tail <= 1'b0;
      end else begin
         exec_tail <= busy;
      end
   end

   // Read data leaves a flip-flop; it is reloaded on every waited cycle
   // so a read held off by an execution returns the updated value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (setup_phase || (access_phase && !pready)) begin
         prdata  <= pwrite ? '0 : next_prdata;
         pslverr <= !hit_any && next_slverr;
      end
   end

endmodule : frd_core

`default_nettype wire

/* File: sim/frd_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************
// Port checker for the decrement core
// ************************************
module frd_core_monitor
   import frd_pkg::*;
(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0]     pwdata,
   input wire logic [DATA_W-1:0]     prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [7:0]            accumulator,
   input wire logic [4:0]            status_flags,
   input wire logic                  busy
);
   logic wr;
   logic start;
   logic valid;
   logic dec_d0;
   assign wr    = psel && penable && pready && pwrite;
   assign start = wr && (paddr == OFS_INSTR);
   assign valid = start && (pwdata[OPC_MSB:OPC_LSB] == OPC_DECREMENT);
   // Remembers the destination so the end of execution can be judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_d0 <= 1'b0;
      end else if (start) begin
         dec_d0 <= valid && !pwdata[DEST_BIT];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_exec_len: assert property (valid |=> busy [*4] ##1 !busy)
      else $error("execution length wrong");
   chk_busy_stall: assert property (busy |-> !pready)
      else $error("bus answered while busy");
   chk_borrow_carry: assert property ($fell(busy) && dec_d0 |->
      status_flags[ST_CARRY] == (accumulator != 8'hff))
      else $error("carry does not match wrap");
   chk_acc_source: assert property ($changed(accumulator) |->
      $past(busy) || $past(wr && paddr == OFS_ACCUM))
      else $error("accumulator changed without cause");
   chk_wb_keep_acc: assert property (valid && pwdata[DEST_BIT] |=>
      $stable(accumulator) [*5])
      else $error("write back touched accumulator");
   chk_zero_neg: assert property ($fell(busy) && dec_d0 |->
      status_flags[ST_ZERO] == (accumulator == 8'h00) && status_flags[ST_NEG] == accumulator[7])
      else $error("zero or negative flag wrong");
   chk_flag_source: assert property ($changed(status_flags) |->
      $past(busy) || $past(wr && paddr == OFS_STATUS))
      else $error("flags changed without cause");
   chk_nib_wrap: assert property ($fell(busy) && dec_d0 |->
      status_flags[ST_NIBBLE] == (accumulator[3:0] != 4'hf) &&
      status_flags[ST_WRAP] == (accumulator == 8'h7f))
      else $error("nibble or wrap flag wrong");
endmodule : frd_core_monitor

bind frd_core frd_core_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .accumulator, .status_flags, .busy);

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import frd_pkg::*;
;
   logic                  pclk;
   logic                  presetn;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [APB_ADDR_W-1:0] paddr;
   logic [DATA_W-1:0]     pwdata;
   logic [DATA_W-1:0]     prdata;
   logic                  pready;
   logic                  pslverr;
   logic [7:0]            accumulator;
   logic [4:0]            status_flags;
   logic                  busy;
   logic [31:0]           r;
   logic                  e;
   int                    num_errors;
   int                    n_tests;

   frd_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .accumulator, .status_flags, .busy);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ************************************
   // Bus tasks
   // ************************************
   task automatic final_report;
      $display("errors %0d tests %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   // Pready and read data are taken at the edge itself, before the flops move
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rdc

   // Seeds one byte, runs one decrement and checks accumulator, flags and memory
   task automatic dec_case(input logic [11:0] m, input logic [7:0] v, input logic d,
                           input logic a, input logic [7:0] f);
      logic [7:0] res;
      logic [4:0] fl;
      res = v - 8'h01;
      fl  = {res[7], v == 8'h80, res == 8'h00, v[3:0] != 4'h0, v != 8'h00};
      wr(OFS_MEM_ADDR, {20'h0, m});
      wr(OFS_MEM_DATA, {24'h0, v});
      wr(OFS_ACCUM, 32'h5a);
      wr(OFS_INSTR, {16'h0, OPC_DECREMENT, d, a, f});
      rdc(OFS_ACCUM, {24'h0, d ? 8'h5a : res});
      rdc(OFS_STATUS, {27'h0, fl});
      rdc(OFS_MEM_DATA, {24'h0, d ? res : v});
   endtask : dec_case

   // ************************************
   // Test sequence
   // ************************************
   initial begin
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      presetn    = 1'b0;
      num_errors = 0;
      n_tests    = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(OFS_ACCUM, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      dec_case(12'h010, 8'h01, 1'b1, 1'b0, 8'h10);
      dec_case(12'h020, 8'h00, 1'b0, 1'b0, 8'h20);
      dec_case(12'hf80, 8'h80, 1'b0, 1'b0, 8'h80);
      wr(OFS_BANK_SEL, 32'h3);
      dec_case(12'h344, 8'h10, 1'b1, 1'b1, 8'h44);
      wr(OFS_CTRL, 32'h1);
      wr(OFS_INDEX_BASE, 32'h200);
      dec_case(12'h205, 8'h3c, 1'b0, 1'b0, 8'h05);
      dec_case(12'h25f, 8'h02, 1'b1, 1'b0, 8'h5f);
      dec_case(12'hf60, 8'hff, 1'b0, 1'b0, 8'h60);
      dec_case(12'h305, 8'h81, 1'b0, 1'b1, 8'h05);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, e}, 32'h1);
      // Wrong opcode must not execute nor touch the flags
      wr(OFS_INSTR, 32'h0);
      rdc(OFS_STATUS, 32'h213);
      wr(OFS_STATUS, 32'h200);
      rdc(OFS_STATUS, 32'h0);
      final_report();
   end

   initial begin
      #50000;
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
endmodule : tb_top

`default_nettype wire
